// ### rtl/sf_cmd_front.sv
/*
 * Serial flash command front end: byte FIFO for read data and the command
 * interpreter that sits behind the chip select, clock and four data pins.
 * Assumes the bus pins are asynchronous to mclk_i and the serial clock is
 * at most a quarter of mclk_i; array reads and program/erase run outside.
 */

// ------------------------------------------------------------
// Read data FIFO
// ------------------------------------------------------------
module sf_byte_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic flush_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	if (D < 2 || (1 << AW) != D || W < 1) begin : g_chk
		$error("sf_byte_fifo: depth must be a power of two of at least 2");
	end
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} fifo_s;
	fifo_s s;
	fifo_s next_s;
	logic push;
	logic pop;

	// Honest flags straight from the fill count
	assign in_ready_o = (s.cnt != (AW+1)'(D));
	assign out_valid_o = (s.cnt != '0);
	assign out_data_o = s.mem[s.rp];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	// Pointer and storage update; flush drops everything held
	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wp] = in_data_i;
			next_s.wp = s.wp + 1'b1;
		end
		if (pop) begin
			next_s.rp = s.rp + 1'b1;
		end
		next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
		if (flush_i) begin
			next_s.wp = '0;
			next_s.rp = '0;
			next_s.cnt = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule // sf_byte_fifo

// ------------------------------------------------------------
// Command interpreter
// ------------------------------------------------------------
module sf_cmd_front #(
	parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary identity value
	parameter logic [7:0] DEVICE_CODE = 8'h3C, // Arbitrary identity value
	parameter logic [15:0] TYPE_CODE = 16'h4D21, // Arbitrary identity value
	parameter int FIFO_DEPTH = 4
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Serial bus pins
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic [3:0] dq_i,
	output logic [3:0] dq_o,
	output logic [3:0] dq_oe_n_o,
	// Array read request and data
	output logic [23:0] rd_addr_o,
	output logic rd_start_o,
	input wire logic [7:0] rd_data_i,
	input wire logic rd_valid_i,
	output logic rd_ready_o,
	// Embedded operation interface
	input wire logic busy_i,
	input wire logic op_done_i,
	input wire logic deep_pd_i,
	output logic wr_go_o,
	output logic [7:0] wr_op_o,
	output logic [23:0] wr_addr_o,
	output logic op_abort_o,
	output logic status_clr_o,
	output logic otp_exit_o,
	// Mode status
	output logic wel_o,
	output logic quad_mode_o,
	output logic enhance_o
);
	import sf_cmd_pkg::*;

	typedef struct packed {
		logic cs_m, cs_s, cs_d;
		logic sck_m, sck_s, sck_d;
		logic [3:0] dq_m, dq_s;
		phase_e ph;
		logic [7:0] op;
		logic [5:0] cnt, target;
		logic [2:0] lanes, out_lanes, nclk, bitmod;
		logic [23:0] addr;
		logic [7:0] sh_in, sh_out;
		logic [1:0] idx;
		logic cont, over, quad, enh, armed, write_enable_latch;
		logic [3:0] dq_out, oe_n;
		logic rd_start, wr_go, abort, clr, otp_exit;
		logic [7:0] wr_op;
	} front_s;
	front_s s;
	front_s next_s;

	logic fifo_valid;
	logic [7:0] fifo_data;
	logic pop;
	logic flush;
	logic rise, fall, cs_fall, cs_rise, exec_cmd;
	logic [7:0] in_byte;
	logic [7:0] out_byte;

	// Clocks a field of the given bits takes on the given number of lanes
	function automatic logic [5:0] clks(input logic [5:0] bits, input logic [2:0] ln);
		clks = (ln == 3'd4) ? (bits >> 2) : (ln == 3'd2) ? (bits >> 1) : bits;
	endfunction

	// Shift one clock of input in, most significant bit first
	function automatic logic [7:0] shin(input logic [7:0] v, input logic [3:0] d,
		input logic [2:0] ln);
		shin = (ln == 3'd4) ? {v[3:0], d} : (ln == 3'd2) ? {v[5:0], d[1:0]} : {v[6:0], d[0]};
	endfunction

	// Commands that must stand alone, one byte in their frame
	function automatic logic is_single(input logic [7:0] op);
		is_single = (op == OP_QUAD_ENTER) || (op == OP_QUAD_RELEASE) || (op == OP_RESET_ARM) ||
			(op == OP_RESET) || (op == OP_WL_SET) || (op == OP_WL_CLR);
	endfunction

	// Identification bytes, repeating while the host keeps clocking
	function automatic logic [7:0] id_byte(input logic [7:0] op, input logic [1:0] i,
		input logic a0);
		if (op == OP_ID_DEV) begin
			id_byte = DEVICE_CODE;
		end else if (op == OP_ID_MAKER_DEV) begin
			id_byte = (i[0] ^ a0) ? DEVICE_CODE : MAKER_CODE;
		end else begin
			id_byte = (i == 2'd0) ? MAKER_CODE : (i == 2'd1) ? TYPE_CODE[15:8] : TYPE_CODE[7:0];
		end
	endfunction

	if (FIFO_DEPTH < 2) begin : g_chk
		$error("sf_cmd_front: FIFO_DEPTH must be at least 2");
	end

	sf_byte_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
		.clk_i(mclk_i),
		.srst_i(srst_i),
		.flush_i(flush),
		.in_valid_i(rd_valid_i),
		.in_ready_o(rd_ready_o),
		.in_data_i(rd_data_i),
		.out_valid_o(fifo_valid),
		.out_ready_i(pop),
		.out_data_o(fifo_data)
	);

	// Edges seen only on the second and third flops of the select and clock synchronisers
	assign rise = s.sck_s && !s.sck_d && !s.cs_s;
	assign fall = !s.sck_s && s.sck_d && !s.cs_s;
	assign cs_fall = !s.cs_s && s.cs_d;
	assign cs_rise = s.cs_s && !s.cs_d;
	assign exec_cmd = cs_rise && (s.ph == PH_SINK) && (s.bitmod == 3'd0) && !s.over;
	assign in_byte = shin(s.sh_in, s.dq_s, s.lanes);
	assign flush = cs_fall;
	// Missing array data reads as zero rather than stalling the host clock
	assign out_byte = (s.op == OP_ID_DEV || s.op == OP_ID_MAKER_DEV || s.op == OP_ID_TYPE) ?
		id_byte(s.op, s.idx, s.addr[0]) : (fifo_valid ? fifo_data : 8'h00);
	assign pop = fall && (s.ph == PH_DATA) && (s.nclk == 3'd0) && fifo_valid &&
		!(s.op == OP_ID_DEV || s.op == OP_ID_MAKER_DEV || s.op == OP_ID_TYPE);

	// ------------------------------------------------------------
	// Frame sequencing and mode state
	// ------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.cs_m = cs_n_i;
		next_s.cs_s = s.cs_m;
		next_s.cs_d = s.cs_s;
		next_s.sck_m = sclk_i;
		next_s.sck_s = s.sck_m;
		next_s.sck_d = s.sck_s;
		next_s.dq_m = dq_i;
		next_s.dq_s = s.dq_m;
		next_s.rd_start = 1'b0;
		next_s.wr_go = 1'b0;
		next_s.abort = 1'b0;
		next_s.clr = 1'b0;
		next_s.otp_exit = 1'b0;
		// Completion clears first so that a set in the same cycle wins
		if (op_done_i) begin
			next_s.write_enable_latch = 1'b0;
		end
		if (cs_fall) begin
			// Continuous mode skips the opcode and starts at the address
			next_s.cnt = '0;
			next_s.bitmod = '0;
			next_s.over = 1'b0;
			next_s.idx = '0;
			next_s.nclk = '0;
			next_s.cont = s.enh;
			next_s.lanes = (s.quad || s.enh) ? 3'd4 : 3'd1;
			next_s.op = s.enh ? OP_QUAD_IO : OP_NONE;
			next_s.ph = deep_pd_i ? PH_SINK : (s.enh ? PH_ADDR : PH_CMD);
		end else if (rise) begin
			next_s.cnt = s.cnt + 6'd1;
			next_s.bitmod = s.bitmod + s.lanes;
			next_s.sh_in = in_byte;
			// Address freezes after its phase so ID byte order and rd_addr_o stay put
			if (s.ph == PH_CMD || s.ph == PH_ADDR) begin
				next_s.addr = (s.lanes == 3'd4) ? {s.addr[19:0], s.dq_s} :
					(s.lanes == 3'd2) ? {s.addr[21:0], s.dq_s[1:0]} : {s.addr[22:0], s.dq_s[0]};
			end
			unique case (s.ph)
				PH_CMD: begin
					if (s.cnt + 6'd1 == clks(BYTE_BITS, s.lanes)) begin
						next_s.op = in_byte;
						next_s.cnt = '0;
						next_s.ph = PH_SINK;
						if (in_byte != OP_RESET_ARM && in_byte != OP_RESET) begin
							next_s.armed = 1'b0;
						end
						unique case (in_byte)
							OP_READ, OP_DUAL_OUT: begin
								next_s.ph = (s.quad || busy_i) ? PH_SINK : PH_ADDR;
								next_s.target = (in_byte == OP_READ) ? 6'd0 : DUMMY_DUAL_OUT;
								next_s.out_lanes = (in_byte == OP_READ) ? 3'd1 : 3'd2;
							end
							OP_DUAL_IO: begin
								next_s.ph = (s.quad || busy_i) ? PH_SINK : PH_ADDR;
								next_s.lanes = 3'd2;
								next_s.target = DUMMY_DUAL_IO;
								next_s.out_lanes = 3'd2;
							end
							OP_FAST: begin
								next_s.ph = busy_i ? PH_SINK : PH_ADDR;
								next_s.target = s.quad ? DUMMY_FAST_QUAD : DUMMY_FAST_SINGLE;
								next_s.out_lanes = s.quad ? 3'd4 : 3'd1;
							end
							OP_QUAD_IO: begin
								next_s.ph = busy_i ? PH_SINK : PH_ADDR;
								next_s.lanes = 3'd4;
								next_s.target = DUMMY_QUAD_IO;
								next_s.out_lanes = 3'd4;
							end
							OP_ID_DEV, OP_ID_MAKER_DEV: begin
								next_s.ph = PH_ADDR;
								next_s.target = 6'd0;
								next_s.out_lanes = s.lanes;
							end
							OP_ID_TYPE: begin
								next_s.ph = PH_DATA;
								next_s.out_lanes = s.lanes;
							end
							OP_QUAD_PROG: begin
								next_s.ph = s.quad ? PH_SINK : PH_ADDR;
								next_s.op = s.quad ? OP_NONE : in_byte;
							end
							OP_PAGE_PROG, OP_SECT_ERASE, OP_HALF_ERASE, OP_BLOCK_ERASE: begin
								next_s.ph = PH_ADDR;
							end
							default: begin
								next_s.ph = PH_SINK;
							end
						endcase
					end
				end
				PH_ADDR: begin
					if (s.cont && s.cnt + 6'd1 == clks(BYTE_BITS, s.lanes) &&
						(in_byte == OP_QUAD_RELEASE || in_byte == OP_RESET_ARM ||
						in_byte == OP_RESET)) begin
						// Continuous read left by FFh or a quad reset opcode
						next_s.enh = 1'b0;
						next_s.cont = 1'b0;
						next_s.op = (in_byte == OP_QUAD_RELEASE) ? OP_NONE : in_byte;
						next_s.ph = PH_SINK;
					end else if (s.cnt + 6'd1 == clks(ADDR_BITS, s.lanes)) begin
						next_s.cnt = '0;
						if (s.cont) begin
							next_s.armed = 1'b0;
						end
						if (s.op == OP_PAGE_PROG || s.op == OP_QUAD_PROG || s.op == OP_SECT_ERASE ||
							s.op == OP_HALF_ERASE || s.op == OP_BLOCK_ERASE) begin
							next_s.ph = PH_SINK;
						end else begin
							next_s.rd_start = !(s.op == OP_ID_DEV || s.op == OP_ID_MAKER_DEV);
							next_s.ph = (s.target == 6'd0) ? PH_DATA : PH_DUMMY;
						end
					end
				end
				PH_DUMMY: begin
					if (s.op == OP_QUAD_IO && s.cnt + 6'd1 == INDICATOR_CLKS) begin
						next_s.enh = (in_byte[7:4] == ENH_KEEP_NIBBLE);
					end
					if (s.cnt + 6'd1 == s.target) begin
						next_s.ph = PH_DATA;
					end
				end
				PH_SINK: begin
					if (is_single(s.op)) begin
						next_s.over = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		// Drive on the falling edge so the host samples stable data
		if (fall && s.ph == PH_DATA) begin
			next_s.oe_n = (s.out_lanes == 3'd4) ? 4'h0 : (s.out_lanes == 3'd2) ? 4'hC : 4'hD;
			if (s.nclk == 3'd0) begin
				next_s.dq_out = (s.out_lanes == 3'd4) ? out_byte[7:4] :
					(s.out_lanes == 3'd2) ? {2'b00, out_byte[7:6]} : {2'b00, out_byte[7], 1'b0};
				next_s.sh_out = shin(out_byte, 4'h0, s.out_lanes);
				next_s.idx = (s.op == OP_ID_TYPE && s.idx == 2'd2) ? 2'd0 : s.idx + 2'd1;
			end else begin
				next_s.dq_out = (s.out_lanes == 3'd4) ? s.sh_out[7:4] :
					(s.out_lanes == 3'd2) ? {2'b00, s.sh_out[7:6]} : {2'b00, s.sh_out[7], 1'b0};
				next_s.sh_out = shin(s.sh_out, 4'h0, s.out_lanes);
			end
			next_s.nclk = (s.nclk + 3'd1 == 3'(clks(BYTE_BITS, s.out_lanes))) ? 3'd0 :
				s.nclk + 3'd1;
		end
		// Deselect ends the stream and executes standalone commands
		if (cs_rise) begin
			next_s.ph = PH_IDLE;
			next_s.oe_n = OE_N_IDLE;
			next_s.dq_out = '0;
			next_s.cont = 1'b0;
			if (exec_cmd) begin
				unique case (s.op)
					OP_QUAD_ENTER: next_s.quad = 1'b1;
					OP_QUAD_RELEASE: next_s.quad = 1'b0;
					OP_RESET_ARM: next_s.armed = 1'b1;
					OP_WL_SET: next_s.write_enable_latch = 1'b1;
					OP_WL_CLR: begin
						next_s.write_enable_latch = 1'b0;
						next_s.otp_exit = 1'b1;
					end
					OP_RESET: begin
						next_s.armed = 1'b0;
						if (s.armed) begin
							next_s.quad = QUAD_RESET;
							next_s.enh = 1'b0;
							next_s.write_enable_latch = WEL_RESET;
							next_s.clr = 1'b1;
							next_s.abort = busy_i;
						end
					end
					OP_STAT_WR, OP_PAGE_PROG, OP_QUAD_PROG, OP_SECT_ERASE, OP_HALF_ERASE,
					OP_BLOCK_ERASE, OP_CHIP_ERASE, OP_CHIP_ERASE_ALT: begin
						next_s.wr_go = s.write_enable_latch && !busy_i;
						next_s.wr_op = s.op;
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			s <= '0;
			s.cs_m <= 1'b1;
			s.cs_s <= 1'b1;
			s.cs_d <= 1'b1;
			s.ph <= PH_IDLE;
			s.oe_n <= OE_N_IDLE;
			s.write_enable_latch <= WEL_RESET;
			s.quad <= QUAD_RESET;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register
	assign dq_o = s.dq_out;
	assign dq_oe_n_o = s.oe_n;
	assign rd_addr_o = s.addr;
	assign rd_start_o = s.rd_start;
	assign wr_go_o = s.wr_go;
	assign wr_op_o = s.wr_op;
	assign wr_addr_o = s.addr;
	assign op_abort_o = s.abort;
	assign status_clr_o = s.clr;
	assign otp_exit_o = s.otp_exit;
	assign wel_o = s.write_enable_latch;
	assign quad_mode_o = s.quad;
	assign enhance_o = s.enh;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	chk_deselect_release: assert property (cs_rise |=> dq_oe_n_o == OE_N_IDLE)
		else $error("data lines still driven after deselect");
	chk_quad_enter: assert property (exec_cmd && s.op == OP_QUAD_ENTER |=> quad_mode_o)
		else $error("quad mode not entered");
	chk_release_single: assert property (exec_cmd && s.op == OP_QUAD_RELEASE && !s.quad
		|=> !quad_mode_o && $stable(wel_o))
		else $error("release acted in single-line mode");
	chk_quad_refuse: assert property (rd_start_o && quad_mode_o
		|-> s.op == OP_FAST || s.op == OP_QUAD_IO)
		else $error("refused read started in quad mode");
	chk_reset_disarm: assert property (rise && s.ph == PH_CMD && s.cnt + 6'd1 ==
		clks(BYTE_BITS, s.lanes) && in_byte != OP_RESET_ARM && in_byte != OP_RESET
		|=> !s.armed)
		else $error("reset still armed after another command");
	chk_reset_effect: assert property (status_clr_o |-> !quad_mode_o && !wel_o
		&& !enhance_o && $past(s.armed, 1))
		else $error("software reset left mode state");
	chk_reset_abort: assert property (status_clr_o |-> op_abort_o == $past(busy_i))
		else $error("abort does not follow busy at reset");
	chk_wel_set: assert property (exec_cmd && s.op == OP_WL_SET |=> wel_o [*2])
		else $error("latch not set by 06h");
	chk_write_gate: assert property (wr_go_o |-> $past(wel_o) && !$past(busy_i))
		else $error("write issued without latch");
	chk_wel_done: assert property (op_done_i && !exec_cmd |=> !wel_o)
		else $error("latch survived completion");
	chk_dpd_keep: assert property (cs_fall && deep_pd_i
		|=> s.ph == PH_SINK && !status_clr_o)
		else $error("frame decoded in deep power-down");

	cov_quad_read: cover property (rise && s.ph == PH_DUMMY && s.op == OP_QUAD_IO ##[1:200]
		fall && s.ph == PH_DATA);
	cov_sw_reset: cover property (status_clr_o);
	cov_enhance: cover property (enhance_o && cs_fall);
	cov_write_go: cover property (wr_go_o);
endmodule // sf_cmd_front

// ### rtl/sf_cmd_pkg.sv
/*
 * Shared constants of the serial flash command front end: opcodes, phase
 * lengths, reset values and the frame phase type.
 * Assumes one 40 MHz system clock that oversamples the serial bus pins.
 */
package sf_cmd_pkg;
	// ------------------------------------------------------------
	// Opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_NONE = 8'h00;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST = 8'h0B;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
	localparam logic [7:0] OP_DUAL_IO = 8'hBB;
	localparam logic [7:0] OP_QUAD_IO = 8'hEB;
	localparam logic [7:0] OP_QUAD_ENTER = 8'h38;
	localparam logic [7:0] OP_QUAD_RELEASE = 8'hFF;
	localparam logic [7:0] OP_RESET_ARM = 8'h66;
	localparam logic [7:0] OP_RESET = 8'h99;
	localparam logic [7:0] OP_WL_SET = 8'h06;
	localparam logic [7:0] OP_WL_CLR = 8'h04;
	localparam logic [7:0] OP_STAT_WR = 8'h01;
	localparam logic [7:0] OP_PAGE_PROG = 8'h02;
	localparam logic [7:0] OP_QUAD_PROG = 8'h32;
	localparam logic [7:0] OP_SECT_ERASE = 8'h20;
	localparam logic [7:0] OP_HALF_ERASE = 8'h52;
	localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
	localparam logic [7:0] OP_CHIP_ERASE = 8'hC7;
	localparam logic [7:0] OP_CHIP_ERASE_ALT = 8'h60;
	localparam logic [7:0] OP_ID_DEV = 8'hAB;
	localparam logic [7:0] OP_ID_MAKER_DEV = 8'h90;
	localparam logic [7:0] OP_ID_TYPE = 8'h9F;
	// ------------------------------------------------------------
	// Phase lengths, in bits or clocks, and the indicator nibble that keeps continuous mode
	// ------------------------------------------------------------
	localparam logic [5:0] BYTE_BITS = 6'd8;
	localparam logic [5:0] ADDR_BITS = 6'd24;
	localparam logic [5:0] DUMMY_FAST_SINGLE = 6'd8;
	localparam logic [5:0] DUMMY_FAST_QUAD = 6'd6;
	localparam logic [5:0] DUMMY_DUAL_OUT = 6'd8;
	localparam logic [5:0] DUMMY_DUAL_IO = 6'd4;
	localparam logic [5:0] DUMMY_QUAD_IO = 6'd6;
	localparam logic [5:0] INDICATOR_CLKS = 6'd2;
	localparam logic [3:0] ENH_KEEP_NIBBLE = 4'hA;
	// ------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------
	localparam logic WEL_RESET = 1'b0;
	localparam logic QUAD_RESET = 1'b0;
	localparam logic [3:0] OE_N_IDLE = 4'hF;
	// Frame phase
	typedef enum logic [2:0] {PH_IDLE, PH_CMD, PH_ADDR, PH_DUMMY, PH_DATA, PH_SINK} phase_e;
endpackage

// ### test/spi_host_model.sv
/*
 * Behavioural serial bus host that plays the far side of the command front end.
 * Assumes a 40 MHz clk_i and drives pins by non-blocking assignment on its edges.
 */
module spi_host_model (
	// Clock
	input wire logic clk_i,
	// Bus pins
	output logic cs_n_o,
	output logic sclk_o,
	output logic [3:0] dq_o,
	input wire logic [3:0] dq_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// Bits seen on the single-line output, one per rising serial clock
	logic [31:0] rx;
	// Idle bus: deselected, clock parked low (mode 0)
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		dq_o = 4'h0;
		rx = '0;
	end
	// One frame of nb bits on 1 or 4 lanes; a 300 ns clock that stands still between frames
	task automatic frame(input logic [63:0] v, input int nb, input int lanes);
		logic [63:0] s;
		s = v << (64 - nb);
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		for (int i = 0; i < nb; i += lanes) begin
			repeat (4) @(posedge clk_i);
			dq_o <= (lanes == 4) ? s[63:60] : {~dq_o[3:1], s[63]}; // MSB first
			s = s << lanes;
			repeat (4) @(posedge clk_i);
			rx <= {rx[30:0], dq_i[1]};
			sclk_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b0;
		end
		repeat (4) @(posedge clk_i);
		cs_n_o <= 1'b1; // Each opcode in its own frame
		dq_o <= ~dq_o; // Released lines must not keep the last value
		repeat (8) @(posedge clk_i);
	endtask
endmodule // spi_host_model

// ### test/tb_sf_cmd_front.sv
/*
 * Self-checking bench of the command front end, one task per scenario.
 * Assumes the host model above; array data and busy come from the bench.
 */
module tb_sf_cmd_front;
	timeunit 1ns;
	timeprecision 1ps;
	import sf_cmd_pkg::*;
	logic mclk_i, srst_i, cs_n, sclk, rd_valid_i, busy_i, op_done_i, deep_pd_i;
	logic [3:0] dq;
	logic [7:0] rd_data_i;
	logic [23:0] rd_addr_o;
	logic rd_start_o, status_clr_o, otp_exit_o, wel_o, quad_mode_o;
	logic rd_ready, wr_go, op_abort, enhance;
	logic [3:0] dq_out, oe_n;
	logic [7:0] wr_op;
	logic [23:0] wr_addr;
	int bad_count = 0, n_checks = 0, n_rd = 0, n_clr = 0, n_otp = 0, n_wr = 0, n_abort = 0;
	// Identity codes handed to the design; the values are arbitrary
	localparam logic [7:0] MK = 8'h6E;
	localparam logic [7:0] DV = 8'h71;
	localparam logic [15:0] TY = 16'h2B47;
	spi_host_model i_host (.clk_i(mclk_i), .cs_n_o(cs_n), .sclk_o(sclk), .dq_o(dq),
		.dq_i(dq_out));
	sf_cmd_front #(.MAKER_CODE(MK), .DEVICE_CODE(DV), .TYPE_CODE(TY)) i_dut (
		.mclk_i(mclk_i), .srst_i(srst_i), .cs_n_i(cs_n), .sclk_i(sclk),
		.dq_i(dq), .dq_o(dq_out), .dq_oe_n_o(oe_n), .rd_addr_o(rd_addr_o),
		.rd_start_o(rd_start_o), .rd_data_i(rd_data_i), .rd_valid_i(rd_valid_i),
		.rd_ready_o(rd_ready), .busy_i(busy_i), .op_done_i(op_done_i), .deep_pd_i(deep_pd_i),
		.wr_go_o(wr_go), .wr_op_o(wr_op), .wr_addr_o(wr_addr), .op_abort_o(op_abort),
		.status_clr_o(status_clr_o), .otp_exit_o(otp_exit_o), .wel_o(wel_o),
		.quad_mode_o(quad_mode_o), .enhance_o(enhance));
	// 40 MHz clock
	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end
	// Pulse counters, so one-cycle outputs are never missed
	always @(posedge mclk_i) begin
		if (rd_start_o === 1'b1) n_rd++;
		if (status_clr_o === 1'b1) n_clr++;
		if (otp_exit_o === 1'b1) n_otp++;
		if (wr_go === 1'b1) n_wr++;
		if (op_abort === 1'b1) n_abort++;
	end
	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	task automatic final_report();
		if (bad_count == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Latch set, clear with one-time area exit, and a frame one bit too long
	task automatic t_latch();
		int o;
		o = n_otp;
		i_host.frame(OP_WL_SET, 8, 1);
		chk(wel_o, 1'b1, "latch not set");
		i_host.frame(OP_WL_CLR, 8, 1);
		chk(wel_o, 1'b0, "latch not cleared");
		chk(n_otp - o, 1, "no area exit");
		i_host.frame({OP_WL_SET, 1'b0}, 9, 1);
		chk(wel_o, 1'b0, "partial byte taken");
	endtask
	// Completed write operation clears the latch
	task automatic t_done();
		i_host.frame(OP_WL_SET, 8, 1);
		@(posedge mclk_i) op_done_i <= 1'b1;
		@(posedge mclk_i) op_done_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		chk(wel_o, 1'b0, "latch kept after done");
	endtask
	// Intervening command disarms, then a proper pair resets
	task automatic t_reset();
		int c;
		c = n_clr;
		i_host.frame(OP_RESET_ARM, 8, 1);
		i_host.frame(OP_WL_SET, 8, 1);
		i_host.frame(OP_RESET, 8, 1);
		chk(n_clr - c, 0, "disarmed reset ran");
		chk(wel_o, 1'b1, "latch lost");
		i_host.frame(OP_RESET_ARM, 8, 1);
		i_host.frame(OP_RESET, 8, 1);
		chk(n_clr - c, 1, "reset not done");
		chk(wel_o, 1'b0, "latch kept by reset");
		repeat (1200) @(posedge mclk_i); // Recovery before the next command
	endtask
	// Single-line read takes the address and streams the first byte
	task automatic t_read();
		int r;
		r = n_rd;
		i_host.frame({OP_READ, 24'h12A5C3, 8'h00}, 40, 1);
		chk(n_rd - r, 1, "read not started");
		chk(rd_addr_o, 24'h12A5C3, "wrong address");
		chk(i_host.rx[7:0], 8'hA5, "wrong read byte");
		chk(oe_n, OE_N_IDLE, "lines driven after deselect");
		chk(rd_ready, 1'b0, "full queue still ready");
	endtask
	// Write gating by the latch, reset abort while busy, frames ignored in power-down
	task automatic t_write();
		int w, a;
		w = n_wr;
		a = n_abort;
		i_host.frame({OP_SECT_ERASE, 24'h001000}, 32, 1);
		chk(n_wr - w, 0, "erase without latch");
		i_host.frame(OP_WL_SET, 8, 1);
		i_host.frame({OP_SECT_ERASE, 24'h001000}, 32, 1);
		chk(n_wr - w, 1, "erase refused");
		chk(wr_op, OP_SECT_ERASE, "wrong write opcode");
		chk(wr_addr, 24'h001000, "wrong erase address");
		@(posedge mclk_i) busy_i <= 1'b1;
		i_host.frame(OP_RESET_ARM, 8, 1);
		i_host.frame(OP_RESET, 8, 1);
		chk(n_abort - a, 1, "busy operation not aborted");
		@(posedge mclk_i) busy_i <= 1'b0;
		repeat (1200) @(posedge mclk_i); // Recovery before the next command
		deep_pd_i <= 1'b1;
		i_host.frame(OP_WL_SET, 8, 1);
		chk(wel_o, 1'b0, "frame taken in deep power-down");
		@(posedge mclk_i) deep_pd_i <= 1'b0;
	endtask
	// Identification codes on the single data line
	task automatic t_id();
		i_host.frame({OP_ID_TYPE, 24'h000000}, 32, 1);
		chk(i_host.rx[23:0], {MK, TY}, "wrong type code");
		i_host.frame({OP_ID_MAKER_DEV, 24'h000001, 16'h0000}, 48, 1);
		chk(i_host.rx[15:0], {DV, MK}, "wrong maker order");
	endtask
	// Continuous quad read kept by the indicator; FFh twice leaves it, then four-line mode
	task automatic t_enh();
		int r;
		i_host.frame(OP_QUAD_ENTER, 8, 1);
		r = n_rd;
		i_host.frame({OP_QUAD_IO, 24'h000100, 8'hA0, 16'h0000}, 56, 4);
		chk(n_rd - r, 1, "quad read refused");
		chk(enhance, 1'b1, "indicator ignored");
		i_host.frame(OP_QUAD_RELEASE, 8, 4);
		chk(enhance, 1'b0, "first release kept continuous");
		chk(quad_mode_o, 1'b1, "first release left quad");
		i_host.frame(OP_QUAD_RELEASE, 8, 4);
		chk(quad_mode_o, 1'b0, "second release ignored");
	endtask
	// Four-line mode: refused read, quad reset, quad release
	task automatic t_quad();
		int r, c;
		i_host.frame(OP_QUAD_ENTER, 8, 1);
		chk(quad_mode_o, 1'b1, "quad not entered");
		r = n_rd;
		c = n_clr;
		i_host.frame({OP_READ, 24'h000040}, 32, 4);
		chk(n_rd - r, 0, "plain read in quad");
		i_host.frame(OP_RESET_ARM, 8, 4);
		i_host.frame(OP_RESET, 8, 4);
		chk(n_clr - c, 1, "quad reset not done");
		chk(quad_mode_o, 1'b0, "reset kept quad");
		i_host.frame(OP_RESET_ARM, 8, 1);
		i_host.frame(OP_RESET, 8, 1);
		chk(n_clr - c, 2, "single pair after quad pair");
		repeat (1200) @(posedge mclk_i); // Recovery before the next command
		i_host.frame(OP_QUAD_ENTER, 8, 1);
		i_host.frame(OP_QUAD_RELEASE, 8, 4);
		chk(quad_mode_o, 1'b0, "release ignored");
		i_host.frame(OP_WL_SET, 8, 1);
		chk(wel_o, 1'b1, "single line lost");
		i_host.frame(OP_QUAD_RELEASE, 8, 1);
		chk(quad_mode_o, 1'b0, "release in single");
		chk(wel_o, 1'b1, "release in single touched latch");
	endtask
	// Watchdog
	initial begin
		repeat (100000) @(posedge mclk_i);
		bad_count++;
		$display("unexpected at %0t: run too long", $time);
		final_report();
	end
	// Main sequence
	initial begin
		srst_i = 1'b1;
		busy_i = 1'b0;
		op_done_i = 1'b0;
		deep_pd_i = 1'b0;
		rd_valid_i = 1'b1;
		rd_data_i = 8'hA5;
		repeat (4) @(posedge mclk_i);
		srst_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		t_latch();
		t_done();
		t_reset();
		t_read();
		t_write();
		t_id();
		t_quad();
		t_enh();
		final_report();
	end
endmodule // tb_sf_cmd_front
